// ---- verilog/upr_router.v ----
// uart packet decoder and usb endpoint router
`timescale 1ns/1ps
`include "upr_map.vh"
// Operation
// [RULE1] only bytes that match the packet framing have any effect; others are dropped.
// [RULE2] a packet with a keyboard or mouse report is sent to the matching hid endpoint.
// [RULE3] cdc traffic coming from the radio controller is sent to the usb cdc endpoint.
// [RULE4] cdc bytes from the usb host are passed back to the radio over the serial link.
// [RULE5] init clears state, lights power, arms interrupts, starts usb, then rx and radio reset.
// [RULE6] header search moves to the length state only after a full valid header.
// [RULE7] the length state takes the length bytes and goes on only if the length is valid.
// [RULE8] the opcode state takes the type bytes and goes on only if the type is known.
// [RULE9] a complete valid payload returns to header search and the packet is processed.
// [RULE10] an invalid payload returns to header search with nothing processed.
// [RULE11] the usb side presents a keyboard, a mouse and a cdc serial function.
// [RULE12] a packet is bd, a7, a two-byte length, a two-byte type code, then parameters.
// [RULE13] type 0x0461 marks a mouse report and 0x0462 a keyboard report.
// [RULE14] mouse payloads lead with a report id, keyboard payloads carry none.
// [RULE15] any framing failure drops partial length, type and payload and resyncs.
module upr_router (
  input wire clk,
  input wire rst,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire rx_err,
  output reg rx_ready,
  input wire usb_enum_done,
  output reg [7:0] ep_data,
  output reg [1:0] ep_sel,
  output reg ep_last,
  output reg ep_valid,
  input wire ep_ready,
  input wire [7:0] cdc_in_data,
  input wire cdc_in_valid,
  output reg cdc_in_ready,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  output reg pwr_led,
  output reg status_led,
  output reg susp_irq_en,
  output reg uart_irq_en,
  output reg usb_start,
  output reg [2:0] usb_funcs,
  output reg uart_rx_en,
  output reg radio_rst,
  output reg pkt_ok,
  output reg pkt_drop
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [2:0] I_START = 3'h1;
  localparam [2:0] I_ENUM = 3'h2;
  localparam [2:0] I_RRST = 3'h4;
  localparam [3:0] I_RUN = 4'h8;
  localparam [7:0] P_HDR0 = 8'h01;
  localparam [7:0] P_HDR1 = 8'h02;
  localparam [7:0] P_LEN0 = 8'h04;
  localparam [7:0] P_LEN1 = 8'h08;
  localparam [7:0] P_OP0 = 8'h10;
  localparam [7:0] P_OP1 = 8'h20;
  localparam [7:0] P_PAY = 8'h40;
  localparam [7:0] P_SEND = 8'h80;
  localparam integer RST_CYC = `UPR_RADIO_RST_CYC;
  localparam [9:0] RST_LAST = RST_CYC[9:0] - 10'h001;
  // ----------------------------------------------------------------------
  // type code to endpoint
  // ----------------------------------------------------------------------
  function [1:0] route_of;
    input [15:0] code;
    begin
      if (code == `UPR_TYPE_MOUSE) begin
        route_of = `UPR_EP_MOUSE;
      end else if (code == `UPR_TYPE_KBD) begin
        route_of = `UPR_EP_KBD;
      end else if (code == `UPR_TYPE_CDC) begin
        route_of = `UPR_EP_CDC;
      end else begin
        route_of = `UPR_EP_NONE;
      end
    end
  endfunction
  reg [3:0] ist_r;
  reg [9:0] rst_cnt_r;
  reg [7:0] pst_r;
  reg [6:0] len_r;
  reg [7:0] len_lo_r;
  reg [7:0] op_lo_r;
  reg [1:0] dest_r;
  reg [6:0] cnt_r;
  reg [7:0] mem_r [0:63];
  reg [7:0] sp_data_r;
  reg [1:0] sp_sel_r;
  reg sp_last_r;
  reg sp_valid_r;
  wire take;
  wire [15:0] len_full;
  wire [1:0] op_dest;
  wire [6:0] cnt_inc;
  wire [7:0] first_byte;
  wire buf_in_ready;
  wire push;
  wire [7:0] push_data;
  wire push_last;
  wire pop;
  assign take = rx_valid & rx_ready;
  assign len_full = {rx_byte, len_lo_r};
  assign op_dest = route_of({rx_byte, op_lo_r});
  assign cnt_inc = cnt_r + 7'h01;
  assign first_byte = (cnt_r == 7'h00) ? rx_byte : mem_r[0];
  assign buf_in_ready = ~sp_valid_r;
  assign push = (pst_r == P_SEND) & buf_in_ready;
  assign push_data = mem_r[cnt_r[5:0]];
  assign push_last = (cnt_inc == len_r);
  assign pop = ep_valid & ep_ready;
  // ----------------------------------------------------------------------
  // init sequence
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ist_r <= {1'b0, I_START};
      rst_cnt_r <= 10'h000;
      pwr_led <= 1'b0;
      status_led <= 1'b0;
      susp_irq_en <= 1'b0;
      uart_irq_en <= 1'b0;
      usb_start <= 1'b0;
      usb_funcs <= 3'h0;
      uart_rx_en <= 1'b0;
      radio_rst <= 1'b0;
    end else begin
      case (ist_r)
        {1'b0, I_START}: begin
          pwr_led <= 1'b1; // [RULE5]
          susp_irq_en <= 1'b1; // [RULE5]
          uart_irq_en <= 1'b1; // [RULE5]
          usb_start <= 1'b1; // [RULE5]
          usb_funcs <= `UPR_USB_FUNCS; // [RULE11]
          ist_r <= {1'b0, I_ENUM};
        end
        {1'b0, I_ENUM}: begin
          if (usb_enum_done) begin
            status_led <= 1'b1; // [RULE5]
            uart_rx_en <= 1'b1; // [RULE5]
            radio_rst <= 1'b1; // [RULE5]
            rst_cnt_r <= 10'h000;
            ist_r <= {1'b0, I_RRST};
          end
        end
        {1'b0, I_RRST}: begin
          if (rst_cnt_r == RST_LAST) begin
            radio_rst <= 1'b0;
            ist_r <= I_RUN;
          end else begin
            rst_cnt_r <= rst_cnt_r + 10'h001;
          end
        end
        default: begin
          ist_r <= I_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // packet parser
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pst_r <= P_HDR0;
      rx_ready <= 1'b0;
      len_r <= 7'h00;
      len_lo_r <= 8'h00;
      op_lo_r <= 8'h00;
      dest_r <= `UPR_EP_NONE;
      cnt_r <= 7'h00;
      pkt_ok <= 1'b0;
      pkt_drop <= 1'b0;
    end else begin
      pkt_ok <= 1'b0;
      pkt_drop <= 1'b0;
      if (ist_r == I_RUN && pst_r != P_SEND) begin
        rx_ready <= 1'b1;
      end
      if (take && rx_err) begin
        pst_r <= P_HDR0; // [RULE1]
        len_r <= 7'h00; // [RULE15]
        op_lo_r <= 8'h00; // [RULE15]
        cnt_r <= 7'h00; // [RULE15]
        pkt_drop <= (pst_r != P_HDR0);
      end else begin
        case (pst_r)
          P_HDR0: begin
            if (take && rx_byte == `UPR_HDR_BYTE0) begin
              pst_r <= P_HDR1; // [RULE6] [RULE12]
            end
          end
          P_HDR1: begin
            if (take) begin
              if (rx_byte == `UPR_HDR_BYTE1) begin
                pst_r <= P_LEN0; // [RULE6] [RULE12]
              end else if (rx_byte != `UPR_HDR_BYTE0) begin
                pst_r <= P_HDR0; // [RULE1]
              end
            end
          end
          P_LEN0: begin
            if (take) begin
              len_lo_r <= rx_byte; // [RULE7]
              pst_r <= P_LEN1;
            end
          end
          P_LEN1: begin
            if (take) begin
              if (len_full != 16'h0000 &&
                  len_full <= {9'h000, `UPR_MAX_PAY}) begin
                len_r <= len_full[6:0]; // [RULE7]
                pst_r <= P_OP0;
              end else begin
                pst_r <= P_HDR0; // [RULE7] [RULE15]
                len_r <= 7'h00;
                pkt_drop <= 1'b1;
              end
            end
          end
          P_OP0: begin
            if (take) begin
              op_lo_r <= rx_byte; // [RULE8]
              pst_r <= P_OP1;
            end
          end
          P_OP1: begin
            if (take) begin
              if (op_dest != `UPR_EP_NONE) begin
                dest_r <= op_dest; // [RULE8] [RULE13]
                cnt_r <= 7'h00;
                pst_r <= P_PAY;
              end else begin
                pst_r <= P_HDR0; // [RULE8] [RULE15]
                len_r <= 7'h00;
                op_lo_r <= 8'h00;
                pkt_drop <= 1'b1;
              end
            end
          end
          P_PAY: begin
            if (take) begin
              mem_r[cnt_r[5:0]] <= rx_byte;
              if (cnt_inc != len_r) begin
                cnt_r <= cnt_inc;
              end else if (dest_r == `UPR_EP_MOUSE &&
                           (len_r < `UPR_MIN_MOUSE_PAY ||
                            first_byte == 8'h00)) begin
                pst_r <= P_HDR0; // [RULE10] [RULE14] [RULE15]
                cnt_r <= 7'h00;
                len_r <= 7'h00;
                pkt_drop <= 1'b1;
              end else begin
                pst_r <= P_SEND; // [RULE9]
                rx_ready <= 1'b0;
                cnt_r <= 7'h00;
              end
            end
          end
          default: begin
            if (push) begin
              cnt_r <= cnt_inc;
              if (push_last) begin
                pst_r <= P_HDR0; // [RULE9]
                cnt_r <= 7'h00;
                pkt_ok <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // two-entry endpoint buffer
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ep_data <= 8'h00;
      ep_sel <= `UPR_EP_NONE;
      ep_last <= 1'b0;
      ep_valid <= 1'b0;
      sp_data_r <= 8'h00;
      sp_sel_r <= `UPR_EP_NONE;
      sp_last_r <= 1'b0;
      sp_valid_r <= 1'b0;
    end else if (pop || !ep_valid) begin
      if (sp_valid_r) begin
        ep_data <= sp_data_r;
        ep_sel <= sp_sel_r;
        ep_last <= sp_last_r;
        ep_valid <= 1'b1;
        sp_valid_r <= 1'b0;
      end else if (push) begin
        ep_data <= push_data; // [RULE2] [RULE3]
        ep_sel <= dest_r; // [RULE2] [RULE3]
        ep_last <= push_last;
        ep_valid <= 1'b1;
      end else begin
        ep_valid <= 1'b0;
      end
    end else if (push) begin
      sp_data_r <= push_data;
      sp_sel_r <= dest_r;
      sp_last_r <= push_last;
      sp_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // host cdc bytes back to the radio
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      cdc_in_ready <= 1'b0;
    end else if (tx_valid) begin
      if (tx_ready) begin
        tx_valid <= 1'b0;
        cdc_in_ready <= 1'b1;
      end
    end else if (cdc_in_valid && cdc_in_ready) begin
      tx_data <= cdc_in_data; // [RULE4]
      tx_valid <= 1'b1; // [RULE4]
      cdc_in_ready <= 1'b0;
    end else if (ist_r == I_RUN) begin
      cdc_in_ready <= 1'b1;
    end
  end
endmodule // upr_router

// ---- pkg/upr_map.vh ----
// framing constants, routing codes and timing counts for the packet router
`ifndef UPR_MAP_VH
`define UPR_MAP_VH

// ----------------------------------------------------------------------
// packet framing
// ----------------------------------------------------------------------
`define UPR_HDR_BYTE0 8'hbd
`define UPR_HDR_BYTE1 8'ha7
`define UPR_TYPE_MOUSE 16'h0461
`define UPR_TYPE_KBD 16'h0462
`define UPR_TYPE_CDC 16'h0463
`define UPR_MAX_PAY 7'h40
`define UPR_MIN_MOUSE_PAY 7'h02

// ----------------------------------------------------------------------
// endpoint select codes
// ----------------------------------------------------------------------
`define UPR_EP_NONE 2'h0
`define UPR_EP_MOUSE 2'h1
`define UPR_EP_KBD 2'h2
`define UPR_EP_CDC 2'h3
`define UPR_USB_FUNCS 3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define UPR_CLK_MHZ 50
`define UPR_RADIO_RST_NS 10000
`define UPR_RADIO_RST_CYC ((`UPR_RADIO_RST_NS * `UPR_CLK_MHZ + 999) / 1000)

`endif

// ---- sim/upr_router_assertions.sv ----
// port-level checks for the packet router
`timescale 1ns/1ps
module upr_router_assertions (
  clk,
  rst,
  rx_ready,
  usb_enum_done,
  ep_data,
  ep_sel,
  ep_valid,
  ep_ready,
  cdc_in_data,
  cdc_in_valid,
  cdc_in_ready,
  tx_data,
  tx_valid,
  tx_ready,
  pwr_led,
  status_led,
  usb_start,
  usb_funcs,
  radio_rst
);
  input wire clk, rst, rx_ready, usb_enum_done, ep_valid, ep_ready;
  input wire cdc_in_valid, cdc_in_ready, tx_valid, tx_ready, pwr_led;
  input wire status_led, usb_start, radio_rst;
  input wire [7:0] ep_data, cdc_in_data, tx_data;
  input wire [1:0] ep_sel;
  input wire [2:0] usb_funcs;
  logic [9:0] rcnt_r;
  // cycles spent with the radio held in reset
  always @(posedge clk) begin
    rcnt_r <= (rst || !radio_rst) ? 10'h000 : rcnt_r + 10'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_tx_done; tx_valid && tx_ready; endsequence
  sequence s_enum_seen; usb_enum_done && usb_start && !status_led;
  endsequence
  property p_init_on;
    $fell(rst) |=> pwr_led && usb_start && usb_funcs == 3'h7;
  endproperty
  property p_enum; s_enum_seen |=> status_led && radio_rst; endproperty
  property p_rr_max; radio_rst |-> rcnt_r < 10'h1f4; endproperty
  property p_rr_end;
    $fell(radio_rst) && !$past(rst) |-> rcnt_r == 10'h1f4 ##1 rx_ready;
  endproperty
  property p_ep_hold;
    ep_valid && !ep_ready |=> ep_valid && $stable(ep_data) && $stable(ep_sel);
  endproperty
  property p_cdc_pass;
    cdc_in_valid && cdc_in_ready |=> tx_valid && tx_data == $past(cdc_in_data);
  endproperty
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  property p_tx_done; s_tx_done |=> !tx_valid && cdc_in_ready; endproperty
  property p_cdc_block; tx_valid |-> !cdc_in_ready; endproperty
  a_init_on: assert property (p_init_on) else $error("init not set");
  a_enum: assert property (p_enum) else $error("enum step");
  a_rr_max: assert property (p_rr_max) else $error("radio long");
  a_rr_end: assert property (p_rr_end) else $error("radio end");
  a_ep_hold: assert property (p_ep_hold) else $error("ep drop");
  a_cdc_pass: assert property (p_cdc_pass) else $error("tx data");
  a_tx_hold: assert property (p_tx_hold) else $error("tx drop");
  a_tx_done: assert property (p_tx_done) else $error("re-ready");
  a_cdc_block: assert property (p_cdc_block) else $error("cdc rdy");
endmodule // upr_router_assertions
bind upr_router upr_router_assertions u_chk (.clk(clk), .rst(rst),
  .rx_ready(rx_ready), .usb_enum_done(usb_enum_done), .ep_data(ep_data),
  .ep_sel(ep_sel), .ep_valid(ep_valid), .ep_ready(ep_ready),
  .cdc_in_data(cdc_in_data), .cdc_in_valid(cdc_in_valid),
  .cdc_in_ready(cdc_in_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .pwr_led(pwr_led), .status_led(status_led),
  .usb_start(usb_start), .usb_funcs(usb_funcs), .radio_rst(radio_rst));

// ---- sim/upr_radio_model.sv ----
// radio-side model: frames packets onto rx, sinks tx bytes
`timescale 1ns/1ps
`include "upr_map.vh"
module upr_radio_model (
  clk,
  rx_byte,
  rx_valid,
  rx_err,
  rx_ready,
  tx_data,
  tx_valid,
  tx_ready
);
  input wire clk;
  output logic [7:0] rx_byte = 8'h00;
  output logic rx_valid = 1'h0;
  output logic rx_err = 1'h0;
  input wire rx_ready;
  input wire [7:0] tx_data;
  input wire tx_valid;
  output logic tx_ready = 1'h0;
  logic slow = 1'h0;
  logic [7:0] tx_q[$];
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'h1;
  always @(posedge clk) if (tx_valid && tx_ready) tx_q.push_back(tx_data);
  // hold each byte until taken, next byte follows at once
  task send_byte(input logic [7:0] b, input logic e);
    @(negedge clk);
    rx_byte = b;
    rx_err = e;
    rx_valid = 1'h1;
    @(posedge clk);
    while (rx_ready !== 1'h1) @(posedge clk);
  endtask
  task idle;
    @(negedge clk);
    rx_valid = 1'h0;
    rx_err = 1'h0;
    rx_byte = ~rx_byte;
  endtask
  task send_pkt(input logic [15:0] typ, input logic [7:0] len,
                input logic [7:0] seed, input int err_at);
    int i;
    send_byte(`UPR_HDR_BYTE0, 1'h0);
    send_byte(`UPR_HDR_BYTE1, 1'h0);
    send_byte(len, 1'h0);
    send_byte(8'h00, 1'h0);
    send_byte(typ[7:0], 1'h0);
    send_byte(typ[15:8], 1'h0);
    // a mouse payload leads with its report id, the seed
    for (i = 0; i < len; i++) send_byte(seed + i[7:0], i == err_at);
    idle();
  endtask
endmodule // upr_radio_model

// ---- sim/tb_upr_router.sv ----
// self-checking bench for the packet router
`timescale 1ns/1ps
`include "upr_map.vh"
module tb_upr_router;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic usb_enum_done = 1'h0;
  logic ep_ready = 1'h0;
  logic stall = 1'h0;
  logic [7:0] cdc_in_data = 8'h00;
  logic cdc_in_valid = 1'h0;
  logic [7:0] rx_byte, ep_data, tx_data;
  logic [1:0] ep_sel;
  logic [2:0] usb_funcs;
  logic rx_valid, rx_err, rx_ready, ep_last, ep_valid, cdc_in_ready, tx_valid;
  logic tx_ready, pwr_led, status_led, susp_irq_en, uart_irq_en, usb_start;
  logic uart_rx_en, radio_rst, pkt_ok, pkt_drop;
  int num_errors = 0;
  int samples_checked = 0;
  logic [10:0] ep_q[$];
  int ok_seen = 0;
  int drop_seen = 0;
  always #10 clk = ~clk;
  upr_router dut (.clk(clk), .rst(rst), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_err(rx_err), .rx_ready(rx_ready),
    .usb_enum_done(usb_enum_done), .ep_data(ep_data), .ep_sel(ep_sel),
    .ep_last(ep_last), .ep_valid(ep_valid), .ep_ready(ep_ready),
    .cdc_in_data(cdc_in_data), .cdc_in_valid(cdc_in_valid),
    .cdc_in_ready(cdc_in_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .pwr_led(pwr_led), .status_led(status_led),
    .susp_irq_en(susp_irq_en), .uart_irq_en(uart_irq_en),
    .usb_start(usb_start), .usb_funcs(usb_funcs), .uart_rx_en(uart_rx_en),
    .radio_rst(radio_rst), .pkt_ok(pkt_ok), .pkt_drop(pkt_drop));
  upr_radio_model radio (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_err(rx_err), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  always @(negedge clk) ep_ready <= stall ? ~ep_ready : 1'h1;
  always @(posedge clk) if (ep_valid && ep_ready) ep_q.push_back({ep_sel,
    ep_last, ep_data});
  always @(posedge clk) begin
    if (pkt_ok === 1'h1) ok_seen++;
    if (pkt_drop === 1'h1) drop_seen++;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task expect_pkt(input logic [1:0] sel, input int len, input logic [7:0] sd);
    int i;
    for (i = 0; i < 600 && ep_q.size() < len; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(ep_q.size(), len);
    for (i = 0; i < len && ep_q.size() > 0; i++)
      chk(ep_q.pop_front(), {sel, i == len - 1, sd + i[7:0]});
    ep_q.delete();
  endtask
  task t_init;
    int i;
    for (i = 0; i < 700 && rx_ready !== 1'h1; i++) @(posedge clk);
    chk({pwr_led, susp_irq_en, uart_irq_en, usb_start, status_led, uart_rx_en,
      radio_rst, usb_funcs}, 16'h03f7);
  endtask
  task t_route;
    radio.send_pkt(`UPR_TYPE_MOUSE, 8'h02, 8'h05, -1);
    expect_pkt(`UPR_EP_MOUSE, 2, 8'h05);
    stall = 1'h1;
    radio.send_pkt(`UPR_TYPE_KBD, 8'h08, 8'h20, -1);
    expect_pkt(`UPR_EP_KBD, 8, 8'h20);
    radio.send_pkt(`UPR_TYPE_CDC, 8'h40, 8'h41, -1);
    expect_pkt(`UPR_EP_CDC, 64, 8'h41);
    stall = 1'h0;
    chk(ok_seen, 3);
    chk(drop_seen, 0);
  endtask
  task t_bad;
    radio.send_byte(8'h12, 1'h0);
    radio.send_pkt(`UPR_TYPE_MOUSE, 8'h00, 8'h05, -1);
    radio.send_pkt(16'h0499, 8'h02, 8'h05, -1);
    radio.send_pkt(`UPR_TYPE_MOUSE, 8'h03, 8'h00, -1);
    radio.send_pkt(`UPR_TYPE_KBD, 8'h04, 8'h30, 2);
    radio.send_byte(`UPR_HDR_BYTE0, 1'h0);
    radio.send_pkt(`UPR_TYPE_KBD, 8'h03, 8'h60, -1);
    expect_pkt(`UPR_EP_KBD, 3, 8'h60);
    chk(drop_seen, 4);
    chk(ok_seen, 4);
  endtask
  task t_host;
    int i;
    radio.slow = 1'h1;
    for (i = 0; i < 3; i++) begin
      @(negedge clk);
      cdc_in_data = 8'hc0 + i[7:0];
      cdc_in_valid = 1'h1;
      @(posedge clk);
      while (cdc_in_ready !== 1'h1) @(posedge clk);
    end
    @(negedge clk);
    cdc_in_valid = 1'h0;
    cdc_in_data = ~cdc_in_data;
    repeat (20) @(posedge clk);
    chk(radio.tx_q.size(), 3);
    for (i = 0; i < 3; i++) chk(radio.tx_q[i], 8'hc0 + i[7:0]);
  endtask
  task print_verdict;
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    chk(status_led, 1'h0);
    usb_enum_done = 1'h1;
    t_init();
    t_route();
    t_bad();
    t_host();
    print_verdict();
  end
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule // tb_upr_router
